// File: logic/dbw_pkg.sv
// shared constants and carrier types for the data buffer write control block
package dbw_pkg;
   // register byte addresses
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] STAT_ADDR = 8'h04;
   // control field positions and reset value
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_RATE_LSB = 2;
   localparam int CTRL_CAL_BIT = 4;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   // status field positions
   localparam int STAT_INHIBIT_BIT = 0;
   localparam int STAT_DIV_LSB = 1;
   localparam int STAT_CAL_BIT = 3;
   localparam int STAT_SHIFT_LSB = 4;
   localparam int STAT_COUNT_LSB = 8;
   // sector numbers used by the pulse decoders and the inhibit flop
   localparam logic [6:0] SEC_ONE = 7'h01;
   localparam logic [6:0] SEC_TWO = 7'h02;
   localparam logic [6:0] SEC_THREE = 7'h03;
   localparam logic [6:0] SEC_SEVEN = 7'h07;
   localparam logic [6:0] SEC_TEN = 7'h0A;
   localparam logic [6:0] SEC_FIFTEEN = 7'h0F;
   // spoke bit patterns on sector bits 3..1 and the 64-79 block on bits 6..4
   localparam logic [2:0] SPOKE_A = 3'h1;
   localparam logic [2:0] SPOKE_B = 3'h4;
   localparam logic [2:0] SPOKE_C = 3'h7;
   localparam logic [2:0] BLOCK_64 = 3'h4;
   // read-out word shape
   localparam logic [5:0] ID_PULSES = 6'h04;
   localparam logic [5:0] WORD_PULSES = 6'h30;
   // read-out rate divisors of the 16.384 kHz train
   localparam logic [10:0] DIV_512 = 11'h020;
   localparam logic [10:0] DIV_256 = 11'h040;
   localparam logic [10:0] DIV_64 = 11'h100;
   localparam logic [10:0] DIV_16 = 11'h400;
   // frame slot codes {x3,x2,x1} within a five-frame group
   localparam logic [2:0] SLOT_1 = 3'h0;
   localparam logic [2:0] SLOT_2 = 3'h1;
   localparam logic [2:0] SLOT_3 = 3'h2;
   localparam logic [2:0] SLOT_4 = 3'h3;
   localparam logic [2:0] SLOT_5 = 3'h4;
   localparam logic [1:0] SECTION_3 = 2'h2;

   typedef enum logic [1:0] {MODE_IDLE, MODE_ALL_SECTOR, MODE_POLAR_SCAN,
      MODE_MULTI_FRAME} dbw_mode_t;
   typedef enum logic [1:0] {SH_IDLE, SH_ID, SH_DATA} dbw_shift_t;

   // sector timing from the spoke generator
   typedef struct packed {
      logic [6:0] sector;
      logic strobe_first;
      logic strobe_second;
      logic selected_sector;
   } dbw_timing_t;

   // status bits entered into lines 5 and 6
   typedef struct packed {
      logic polarity_select;
      logic suppression_flag;
      logic rate_status;
      logic step_sequence_status;
      logic mode_control_a;
      logic mode_control_b;
      logic sun_delay_mode_flag;
      logic sector_group_a;
      logic sector_group_b;
   } dbw_status_t;

   // write address counters of the buffer storage
   typedef struct packed {
      logic [1:0] section;
      logic x_write_bit3;
      logic x_write_bit2;
      logic x_write_bit1;
      logic y_write_low_bit;
   } dbw_waddr_t;
endpackage

// File: logic/dbw_rate_div.sv
// divider that turns the 16.384 kHz train into the read-out bit rate
`timescale 1ns/1ps
module dbw_rate_div #(
   parameter int CW = 11
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic train_tick,
   input wire logic [1:0] rate_sel,
   output logic rate_tick_q
);
   logic [CW-1:0] div_cnt_q;
   logic [CW-1:0] divisor;

   // rate select picks 512, 256, 64 or 16 bits per second
   always_comb
   begin
      unique case (rate_sel)
         2'h0: divisor = CW'(dbw_pkg::DIV_512);
         2'h1: divisor = CW'(dbw_pkg::DIV_256);
         2'h2: divisor = CW'(dbw_pkg::DIV_64);
         2'h3: divisor = CW'(dbw_pkg::DIV_16);
      endcase
   end

   // count train ticks; a rate change applies at once to the count in progress
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         div_cnt_q <= '0;
         rate_tick_q <= 1'b0;
      end
      else
      begin
         rate_tick_q <= 1'b0;
         if (train_tick)
         begin
            if (div_cnt_q >= divisor - CW'(1))
            begin
               div_cnt_q <= '0;
               rate_tick_q <= 1'b1;
            end
            else
               div_cnt_q <= div_cnt_q + CW'(1);
         end
      end
   end
endmodule

// File: logic/dbw_write_control.sv
// write pulse, read-out shift, calibration and status decoder for the core buffer
`timescale 1ns/1ps
// How it works
// - all-sector writes at second strobe, selected sectors
// - all-sector extra writes, first strobe 66,72,78
// - polar scan writes second strobe 2-7, 10
// - polar scan extra writes first strobe 2,10
// - multi-frame writes 2,3; sector 1 on 10
// - buffer empty presets divider; first advance toggles
// - second stage set fires one-shot toggling first
// - mode pulses ORed, blocked by zero or inhibit
// - fast rate, full, sector 15 sets inhibit
// - after full clears, next sector 15 releases
// - train divided by 32,64,256,1024 for rate
// - gate rise presets counter; four frame-id shifts
// - next 44 pulses shift data, then read advance
// - calibrate command drives sun delay control
// - sun delay sets calibrate latch; electron start clears
// - calibrate forces half-scale flux pulse width
// - status bits written in pairs, lines 5, 6
// - low y bit selects line 5 or 6
// - all-sector/polar frame slots carry fixed status pairs
// - x bits decode frame slot in group
module dbw_write_control (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire dbw_pkg::dbw_timing_t timing,
   input wire logic sun_pulse,
   input wire logic high_voltage_advance,
   input wire logic high_voltage_zero,
   input wire logic buffer_empty,
   input wire logic buffer_full,
   input wire logic fast_bit_rate,
   input wire logic second_premode_all_sector,
   input wire logic train_tick,
   input wire logic shift_pulse,
   input wire logic word_gate,
   input wire logic electron_start,
   input wire dbw_pkg::dbw_status_t status,
   input wire dbw_pkg::dbw_waddr_t waddr,
   output logic write_pulse,
   output logic advance_gated,
   output logic sun_delay_control,
   output logic inflight_calibrate,
   output logic flux_half_scale,
   output logic rate_tick,
   output logic frame_id_shift,
   output logic data_shift,
   output logic y_read_advance,
   output logic misc_status_bit
);
   logic [4:0] ctrl_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic wr_en;
   logic addr_ok;
   dbw_pkg::dbw_mode_t mode;
   logic div1_q;
   logic div2_q;
   logic div2_prev_q;
   logic one_shot_q;
   logic inhibit_q;
   logic wp_as;
   logic wp_ps;
   logic wp_mfs;
   logic wp_q;
   logic adv_q;
   logic [2:0] spoke;
   logic in_block_64;
   logic sun_delay_q;
   logic cal_latch_q;
   logic flux_half_q;
   logic word_gate_prev_q;
   dbw_pkg::dbw_shift_t shift_state_q;
   logic [5:0] shift_cnt_q;
   logic id_shift_q;
   logic data_shift_q;
   logic y_adv_q;
   logic [2:0] slot;
   logic status_bit;
   logic status_q;
   logic rate_tick_w;

   assign mode = dbw_pkg::dbw_mode_t'(ctrl_q[dbw_pkg::CTRL_MODE_LSB +: 2]);
   assign wr_en = psel & penable & pready_q & pwrite;
   assign addr_ok = (paddr == dbw_pkg::CTRL_ADDR) || (paddr == dbw_pkg::STAT_ADDR);

   // apb slave: answer is prepared in the setup cycle so pready is a flop
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         pready_q <= psel & ~penable;
         pslverr_q <= psel & ~penable & ~addr_ok;
         prdata_q <= 32'h0000_0000;
         if (psel & ~penable & ~pwrite)
         begin
            if (paddr == dbw_pkg::CTRL_ADDR)
               prdata_q <= {27'h0, ctrl_q};
            else if (paddr == dbw_pkg::STAT_ADDR)
            begin
               prdata_q[dbw_pkg::STAT_INHIBIT_BIT] <= inhibit_q;
               prdata_q[dbw_pkg::STAT_DIV_LSB +: 2] <= {div2_q, div1_q};
               prdata_q[dbw_pkg::STAT_CAL_BIT] <= cal_latch_q;
               prdata_q[dbw_pkg::STAT_SHIFT_LSB +: 2] <= shift_state_q;
               prdata_q[dbw_pkg::STAT_COUNT_LSB +: 6] <= shift_cnt_q;
            end
         end
      end
   end

   // control register: mode, read-out rate and calibrate command
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ctrl_q <= dbw_pkg::CTRL_RESET;
      else if (wr_en && paddr == dbw_pkg::CTRL_ADDR)
         ctrl_q <= pwdata[4:0];
   end

   // spoke decode: sector bits 3..1 and the 64-79 block
   assign spoke = timing.sector[3:1];
   assign in_block_64 = timing.sector[6:4] == dbw_pkg::BLOCK_64;

   // all-sector pulses
   always_comb
   begin
      wp_as = timing.strobe_second & timing.selected_sector;
      if (timing.strobe_first && in_block_64 && !timing.sector[0] &&
         (spoke == dbw_pkg::SPOKE_A || spoke == dbw_pkg::SPOKE_B ||
         spoke == dbw_pkg::SPOKE_C))
         wp_as = 1'b1;
   end

   // polar scan pulses
   always_comb
   begin
      wp_ps = 1'b0;
      if (timing.strobe_second && timing.sector >= dbw_pkg::SEC_TWO &&
         timing.sector <= dbw_pkg::SEC_SEVEN)
         wp_ps = 1'b1;
      if (timing.strobe_second && timing.sector == dbw_pkg::SEC_TEN)
         wp_ps = 1'b1;
      if (timing.strobe_first && (timing.sector == dbw_pkg::SEC_TWO ||
         timing.sector == dbw_pkg::SEC_TEN))
         wp_ps = 1'b1;
   end

   // multi-frame pulses; sector 1 only on one divider phase
   always_comb
   begin
      wp_mfs = 1'b0;
      if (timing.strobe_second && (timing.sector == dbw_pkg::SEC_TWO ||
         timing.sector == dbw_pkg::SEC_THREE))
         wp_mfs = 1'b1;
      if (timing.strobe_second && timing.sector == dbw_pkg::SEC_ONE &&
         div1_q && !div2_q)
         wp_mfs = 1'b1;
   end

   // composite pulse; only the active mode's decoder is passed
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         wp_q <= 1'b0;
      else
         wp_q <= ((wp_as && mode == dbw_pkg::MODE_ALL_SECTOR) ||
            (wp_ps && mode == dbw_pkg::MODE_POLAR_SCAN) ||
            (wp_mfs && mode == dbw_pkg::MODE_MULTI_FRAME)) &&
            !high_voltage_zero && !inhibit_q;
   end

   // advance passed on unless inhibited
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         adv_q <= 1'b0;
      else
         adv_q <= high_voltage_advance & ~inhibit_q;
   end

   // divide-by-three: stage two toggles on stage one falling; its rise fires
   // a one-shot that flips stage one back, skipping the fourth state
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         div1_q <= 1'b1;
         div2_q <= 1'b1;
         div2_prev_q <= 1'b1;
         one_shot_q <= 1'b0;
      end
      else
      begin
         div2_prev_q <= div2_q;
         one_shot_q <= div2_q & ~div2_prev_q;
         if (buffer_empty)
         begin
            div1_q <= 1'b1;
            div2_q <= 1'b1;
            div2_prev_q <= 1'b1; // a preset of stage two must not fire the one-shot
            one_shot_q <= 1'b0;
         end
         else if (one_shot_q)
            div1_q <= ~div1_q;
         else if (high_voltage_advance && !inhibit_q)
         begin
            div1_q <= ~div1_q;
            if (div1_q)
               div2_q <= ~div2_q;
         end
      end
   end

   // inhibit flop, sampled at the first strobe of sector 15 at fast rate
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         inhibit_q <= 1'b0;
      else if (fast_bit_rate && timing.strobe_first &&
         timing.sector == dbw_pkg::SEC_FIFTEEN)
      begin
         if (buffer_full && !second_premode_all_sector)
            inhibit_q <= 1'b1;
         else if (!buffer_full)
            inhibit_q <= 1'b0;
      end
   end

   // read-out rate divider
   dbw_rate_div #(
      .CW(11)
   ) u_rate_div (
      .clk(clk),
      .rst(rst),
      .train_tick(train_tick),
      .rate_sel(ctrl_q[dbw_pkg::CTRL_RATE_LSB +: 2]),
      .rate_tick_q(rate_tick_w)
   );

   // read-out word: gate rise presets the count, four id shifts, then data
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         word_gate_prev_q <= 1'b1; // gate idles high, so no false start after reset
         shift_state_q <= dbw_pkg::SH_IDLE;
         shift_cnt_q <= 6'h00;
         id_shift_q <= 1'b0;
         data_shift_q <= 1'b0;
      end
      else
      begin
         word_gate_prev_q <= word_gate;
         id_shift_q <= 1'b0;
         data_shift_q <= 1'b0;
         if (!word_gate_prev_q && word_gate)
         begin
            shift_state_q <= dbw_pkg::SH_ID;
            shift_cnt_q <= 6'h00;
         end
         else if (shift_pulse)
         begin
            unique case (shift_state_q)
               dbw_pkg::SH_IDLE:
               begin
                  shift_cnt_q <= shift_cnt_q;
               end
               dbw_pkg::SH_ID:
               begin
                  id_shift_q <= 1'b1;
                  shift_cnt_q <= shift_cnt_q + 6'h01;
                  if (shift_cnt_q == dbw_pkg::ID_PULSES - 6'h01)
                     shift_state_q <= dbw_pkg::SH_DATA;
               end
               dbw_pkg::SH_DATA:
               begin
                  data_shift_q <= 1'b1;
                  shift_cnt_q <= shift_cnt_q + 6'h01;
                  if (shift_cnt_q == dbw_pkg::WORD_PULSES - 6'h01)
                     shift_state_q <= dbw_pkg::SH_IDLE;
               end
               default:
                  shift_state_q <= dbw_pkg::SH_IDLE;
            endcase
         end
      end
   end

   // read advance follows the trailing edge of each data shift
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         y_adv_q <= 1'b0;
      else
         y_adv_q <= data_shift_q;
   end

   // calibration: command drives sun delay; latch held until electron start
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sun_delay_q <= 1'b0;
         cal_latch_q <= 1'b0;
         flux_half_q <= 1'b0;
      end
      else
      begin
         sun_delay_q <= ctrl_q[dbw_pkg::CTRL_CAL_BIT];
         if (sun_delay_q)
            cal_latch_q <= 1'b1;
         else if (electron_start)
            cal_latch_q <= 1'b0;
         flux_half_q <= cal_latch_q;
      end
   end

   // frame slot from x write bits
   assign slot = {waddr.x_write_bit3, waddr.x_write_bit2, waddr.x_write_bit1};

   // status decoder: low y bit picks line 5 (clear) or line 6 (set)
   always_comb
   begin
      status_bit = 1'b0;
      if (mode == dbw_pkg::MODE_MULTI_FRAME)
      begin
         if (slot == dbw_pkg::SLOT_1 && waddr.section != dbw_pkg::SECTION_3)
            status_bit = waddr.y_write_low_bit ? status.suppression_flag
               : status.polarity_select;
         else if ((slot != dbw_pkg::SLOT_1 && slot <= dbw_pkg::SLOT_5 &&
            waddr.section != dbw_pkg::SECTION_3) ||
            (slot == dbw_pkg::SLOT_5 && waddr.section == dbw_pkg::SECTION_3))
            status_bit = waddr.y_write_low_bit ? status.sector_group_b
               : status.sector_group_a;
      end
      else
      begin
         unique case (slot)
            dbw_pkg::SLOT_1:
               status_bit = waddr.y_write_low_bit ? status.suppression_flag
                  : status.polarity_select;
            dbw_pkg::SLOT_2:
               status_bit = waddr.y_write_low_bit ? status.step_sequence_status
                  : status.rate_status;
            dbw_pkg::SLOT_3:
               status_bit = waddr.y_write_low_bit ? status.mode_control_b
                  : status.mode_control_a;
            dbw_pkg::SLOT_4:
               status_bit = waddr.y_write_low_bit ? status.sun_delay_mode_flag
                  : cal_latch_q;
            dbw_pkg::SLOT_5:
               status_bit = waddr.y_write_low_bit ? status.sector_group_b
                  : status.sector_group_a;
            default:
               status_bit = 1'b0;
         endcase
      end
   end

   // registered so the bit is steady through the two-pulse write train
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         status_q <= 1'b0;
      else
         status_q <= status_bit;
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign write_pulse = wp_q;
   assign advance_gated = adv_q;
   assign sun_delay_control = sun_delay_q;
   assign inflight_calibrate = cal_latch_q;
   assign flux_half_scale = flux_half_q;
   assign rate_tick = rate_tick_w;
   assign frame_id_shift = id_shift_q;
   assign data_shift = data_shift_q;
   assign y_read_advance = y_adv_q;
   assign misc_status_bit = status_q;

   // checks
   property p_as_write;
      @(posedge clk) disable iff (rst)
      (mode == dbw_pkg::MODE_ALL_SECTOR && timing.strobe_second &&
      timing.selected_sector && !high_voltage_zero && !inhibit_q) |=> wp_q;
   endproperty
   a_as_write: assert property (p_as_write) else $error("as write missing");

   property p_as_extra;
      @(posedge clk) disable iff (rst)
      (mode == dbw_pkg::MODE_ALL_SECTOR && timing.strobe_first &&
      timing.sector == 7'h48 && !high_voltage_zero && !inhibit_q) |=> wp_q;
   endproperty
   a_as_extra: assert property (p_as_extra) else $error("as sector 72 write missing");

   property p_ps_write;
      @(posedge clk) disable iff (rst)
      (mode == dbw_pkg::MODE_POLAR_SCAN && timing.strobe_first &&
      timing.sector == 7'h05 && !timing.strobe_second) |=> !wp_q;
   endproperty
   a_ps_write: assert property (p_ps_write) else $error("ps spurious write");

   property p_blocked;
      @(posedge clk) disable iff (rst)
      (high_voltage_zero || inhibit_q) |=> !wp_q;
   endproperty
   a_blocked: assert property (p_blocked) else $error("write not blocked");

   property p_preset;
      @(posedge clk) disable iff (rst)
      buffer_empty |=> (div1_q && div2_q);
   endproperty
   a_preset: assert property (p_preset) else $error("divider not preset");

   property p_three_state;
      @(posedge clk) disable iff (rst)
      (div2_q && !div1_q) |-> ##[1:2] div1_q;
   endproperty
   a_three_state: assert property (p_three_state) else $error("illegal divider state");

   property p_inhibit_set;
      @(posedge clk) disable iff (rst)
      (fast_bit_rate && timing.strobe_first && timing.sector == dbw_pkg::SEC_FIFTEEN &&
      buffer_full && !second_premode_all_sector) |=> inhibit_q ##1 !adv_q;
   endproperty
   a_inhibit_set: assert property (p_inhibit_set) else $error("inhibit not set");

   property p_inhibit_hold;
      @(posedge clk) disable iff (rst)
      (inhibit_q && !(timing.strobe_first && timing.sector == dbw_pkg::SEC_FIFTEEN))
      |=> inhibit_q;
   endproperty
   a_inhibit_hold: assert property (p_inhibit_hold) else $error("inhibit dropped early");

   property p_y_adv;
      @(posedge clk) disable iff (rst)
      $fell(data_shift_q) |-> y_adv_q;
   endproperty
   a_y_adv: assert property (p_y_adv) else $error("read advance missing");

   property p_cal;
      @(posedge clk) disable iff (rst)
      $rose(sun_delay_q) |=> cal_latch_q ##1 flux_half_q;
   endproperty
   a_cal: assert property (p_cal) else $error("calibrate latch not set");
endmodule

// File: sim/dbw_telemetry_model.sv
// telemetry timing model: six-pulse shift groups and the word gate
`timescale 1ns/1ps
module dbw_telemetry_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   output logic shift_pulse,
   output logic word_gate
);
   logic [3:0] pos_q;
   logic [4:0] grp_q;
   // pulses on even slots 0..10, slot 12 is the missing seventh position
   assign shift_pulse = run && pos_q < 4'hC && !pos_q[0];
   // gate high for groups 0..7, low for 8..31; stands high while idle
   assign word_gate = grp_q < 5'h8;
   // group steps after slot 11 so the gate only moves inside the gap
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pos_q <= 4'h0;
         grp_q <= 5'h0;
      end
      else
      begin
         pos_q <= (!run || pos_q == 4'hD) ? 4'h0 : pos_q + 4'h1;
         grp_q <= !run ? 5'h0 : grp_q + 5'(pos_q == 4'hB);
      end
   end
endmodule

// File: sim/dbw_write_control_bench.sv
// self-checking bench for the data buffer write control block
`timescale 1ns/1ps
module dbw_write_control_bench;
   logic clk = '0, rst = '1, psel = '0, penable = '0, pwrite = '0, pready, pslverr, err;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   dbw_pkg::dbw_timing_t timing = '0;
   dbw_pkg::dbw_status_t status = '0;
   dbw_pkg::dbw_waddr_t waddr = '0;
   logic sun_pulse = '0, high_voltage_advance = '0, high_voltage_zero = '0, buffer_empty = '0;
   logic buffer_full = '0, fast_bit_rate = '0, second_premode_all_sector = '0;
   logic train_tick = '0, electron_start = '0, run = '0, shift_pulse, word_gate;
   logic write_pulse, advance_gated, sun_delay_control, inflight_calibrate, flux_half_scale;
   logic rate_tick, frame_id_shift, data_shift, y_read_advance, misc_status_bit;
   logic [10:0] divs [4] = '{dbw_pkg::DIV_512, dbw_pkg::DIV_256, dbw_pkg::DIV_64, dbw_pkg::DIV_16};
   int num_errors = 0, n_compared = 0, cyc = 0, n_id = 0, n_dat = 0, n_adv = 0, k, n;

   dbw_write_control dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .timing, .sun_pulse, .high_voltage_advance, .high_voltage_zero,
      .buffer_empty, .buffer_full, .fast_bit_rate, .second_premode_all_sector, .train_tick,
      .shift_pulse, .word_gate, .electron_start, .status, .waddr, .write_pulse,
      .advance_gated, .sun_delay_control, .inflight_calibrate, .flux_half_scale, .rate_tick,
      .frame_id_shift, .data_shift, .y_read_advance, .misc_status_bit);
   dbw_telemetry_model tm_u (.clk, .rst, .run, .shift_pulse, .word_gate);

   // 40 MHz clock; train runs at half the clock so divider gaps stay short
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) train_tick <= ~train_tick;
   // pulse counters sampled mid-cycle, clear of the launching edge
   always @(negedge clk)
   begin
      n_id += int'(frame_id_shift === 1'h1);
      n_dat += int'(data_shift === 1'h1);
      n_adv += int'(y_read_advance === 1'h1);
   end
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         num_errors++;
         final_report;
      end
   end

   task final_report;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one apb transfer; pready and the answer are taken at the rising edge that ends it
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do
         @(posedge clk);
      while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // one strobe cycle, then the write pulse is looked at in the following cycle
   task strobe(input logic [6:0] s, input logic f, input logic sc, input logic sel,
      input logic exp);
      @(posedge clk);
      timing <= {s, f, sc, sel};
      @(posedge clk);
      timing <= '0;
      @(negedge clk);
      chk("write_pulse", write_pulse, exp);
      @(posedge clk);
   endtask

   task adv(input logic exp);
      @(posedge clk);
      high_voltage_advance <= 1'h1;
      @(posedge clk);
      high_voltage_advance <= 1'h0;
      @(negedge clk);
      chk("advance_gated", advance_gated, exp);
      @(posedge clk);
   endtask

   // selected bit alone must give exp; all other bits set must not appear
   task stat(input dbw_pkg::dbw_waddr_t wa, input int b, input logic exp);
      @(posedge clk);
      waddr <= wa;
      status <= 9'h001 << b;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("misc alone", misc_status_bit, exp);
      @(posedge clk);
      status <= ~(9'h001 << b);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("misc others", misc_status_bit, 1'h0);
   endtask

   task gap;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (rate_tick !== 1'h1 && n < 5000);
   endtask

   task wait_gate(input logic v);
      do
      begin
         @(negedge clk);
         n++;
      end
      while (word_gate !== v && n < 3000);
   endtask

   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      apb(1'h0, dbw_pkg::CTRL_ADDR, '0);
      chk("ctrl reset", rd, 32'(dbw_pkg::CTRL_RESET));
      apb(1'h1, dbw_pkg::CTRL_ADDR, 32'hFFFFFFE3);
      apb(1'h0, dbw_pkg::CTRL_ADDR, '0);
      chk("ctrl", rd, 32'h00000003);
      apb(1'h1, 8'h08, 32'hFFFFFFFF);
      chk("slverr", err, 1'h1);
      apb(1'h0, 8'h08, '0);
      chk("unmapped", rd, '0);
      $display("done registers");
      apb(1'h1, dbw_pkg::CTRL_ADDR, 32'h00000002);
      for (k = 1; k < 12; k++)
      begin
         strobe(7'(k), 1'h0, 1'h1, 1'h0, (k >= 2 && k <= 7) || k == 10);
         strobe(7'(k), 1'h1, 1'h0, 1'h0, k == 2 || k == 10);
      end
      apb(1'h1, dbw_pkg::CTRL_ADDR, 32'h00000001);
      strobe(7'h30, 1'h0, 1'h1, 1'h1, 1'h1);
      strobe(7'h30, 1'h0, 1'h1, 1'h0, 1'h0);
      for (k = 64; k < 80; k++)
         strobe(7'(k), 1'h1, 1'h0, 1'h0, k == 66 || k == 72 || k == 78);
      @(posedge clk);
      high_voltage_zero <= 1'h1;
      strobe(7'h30, 1'h0, 1'h1, 1'h1, 1'h0);
      high_voltage_zero <= 1'h0;
      $display("done write pulses");
      apb(1'h1, dbw_pkg::CTRL_ADDR, 32'h00000003);
      @(posedge clk);
      buffer_empty <= 1'h1;
      @(posedge clk);
      buffer_empty <= 1'h0;
      strobe(dbw_pkg::SEC_ONE, 1'h0, 1'h1, 1'h0, 1'h0);
      strobe(dbw_pkg::SEC_THREE, 1'h0, 1'h1, 1'h0, 1'h1);
      adv(1'h1);
      adv(1'h1);
      apb(1'h0, dbw_pkg::STAT_ADDR, '0);
      chk("stages", rd[2:1], 2'h1);
      strobe(dbw_pkg::SEC_ONE, 1'h0, 1'h1, 1'h0, 1'h1);
      adv(1'h1);
      apb(1'h0, dbw_pkg::STAT_ADDR, '0);
      chk("stages", rd[2:1], 2'h3);
      fast_bit_rate <= 1'h1;
      buffer_full <= 1'h1;
      strobe(dbw_pkg::SEC_FIFTEEN, 1'h1, 1'h0, 1'h0, 1'h0);
      strobe(dbw_pkg::SEC_TWO, 1'h0, 1'h1, 1'h0, 1'h0);
      adv(1'h0);
      buffer_full <= 1'h0;
      strobe(dbw_pkg::SEC_TWO, 1'h0, 1'h1, 1'h0, 1'h0);
      strobe(dbw_pkg::SEC_FIFTEEN, 1'h1, 1'h0, 1'h0, 1'h0);
      strobe(dbw_pkg::SEC_TWO, 1'h0, 1'h1, 1'h0, 1'h1);
      fast_bit_rate <= 1'h0;
      $display("done divider and inhibit");
      apb(1'h1, dbw_pkg::CTRL_ADDR, 32'h00000011);
      waddr <= {2'h0, dbw_pkg::SLOT_4, 1'h0};
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("sun_delay", sun_delay_control, 1'h1);
      chk("calibrate", inflight_calibrate, 1'h1);
      chk("half_scale", flux_half_scale, 1'h1);
      chk("misc cal", misc_status_bit, 1'h1);
      apb(1'h1, dbw_pkg::CTRL_ADDR, 32'h00000001);
      repeat (2) @(posedge clk);
      electron_start <= 1'h1;
      @(posedge clk);
      electron_start <= 1'h0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("sun_delay", sun_delay_control, 1'h0);
      chk("calibrate", inflight_calibrate, 1'h0);
      chk("half_scale", flux_half_scale, 1'h0);
      for (k = 0; k < 10; k++)
         if (k != 6)
            stat({2'h0, 3'(k / 2), 1'(k % 2)}, k < 6 ? 8 - k : 9 - k, 1'h1);
      apb(1'h1, dbw_pkg::CTRL_ADDR, 32'h00000003);
      stat({2'h0, dbw_pkg::SLOT_1, 1'h0}, 8, 1'h1);
      stat({2'h1, dbw_pkg::SLOT_1, 1'h1}, 7, 1'h1);
      stat({2'h1, dbw_pkg::SLOT_3, 1'h1}, 0, 1'h1);
      stat({dbw_pkg::SECTION_3, dbw_pkg::SLOT_1, 1'h0}, 8, 1'h0);
      stat({dbw_pkg::SECTION_3, dbw_pkg::SLOT_5, 1'h0}, 1, 1'h1);
      $display("done calibration and status");
      for (k = 0; k < 4; k++)
      begin
         apb(1'h1, dbw_pkg::CTRL_ADDR, 32'(k * 4));
         repeat (3) gap;
         chk("rate gap", 32'(n), 32'(divs[k]) * 2);
      end
      $display("done rate");
      @(posedge clk);
      run <= 1'h1;
      n = 0;
      wait_gate(1'h0);
      n_id = 0;
      n_dat = 0;
      n_adv = 0;
      wait_gate(1'h1);
      wait_gate(1'h0);
      repeat (4) @(negedge clk);
      chk("id shifts", 32'(n_id), 32'(dbw_pkg::ID_PULSES));
      chk("data shifts", 32'(n_dat), 32'(dbw_pkg::WORD_PULSES - dbw_pkg::ID_PULSES));
      chk("read advances", 32'(n_adv), 32'h0000002C);
      $display("done read-out");
      final_report;
   end
endmodule
